// ===== cwc_top.sv
`timescale 1ns/100ps
`include "cwc_params.svh"
module cwc_top #(
   parameter int FS_DIV = `CWC_FS_DIV
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wrData,
   input  wire logic        wrEn,
   input  wire logic        rdEn,
   output logic      [31:0] rdData,
   input  wire logic        cecIn,
   output logic             cecOut,
   output logic             cecOeN,
   output logic             waveErrReq,
   output logic             txDoneReq
);
   logic                  fsTick;
   logic                  rxEnable;
   cwc_pkg::cwc_rx_cfg_t  rxCfg;
   cwc_pkg::cwc_tx_cfg_t  txCfg;
   logic                  txEnable;
   logic                  txTrans;
   logic [7:0]            txByte;
   logic                  txEom;
   logic                  waveErrFlag;
   logic                  txDoneFlag;
   cwc_pkg::cwc_tx_state_t txState;
   logic [7:0]            txCount;
   logic [3:0]            txBitIdx;
   logic [9:0]            txShift;
   logic                  lineLast;
   logic                  rxActive;
   logic [7:0]            rxCount;
   logic                  waveErrEvt;
   logic                  txDoneEvt;
   logic                  wrTxEn;
   logic [7:0]            limEarlyOne;
   logic [7:0]            limLateOne;
   logic [7:0]            limEarlyZero;
   logic [7:0]            limLateZero;
   logic [7:0]            startRise;
   logic [7:0]            startPeriod;
   logic [7:0]            dataRise;
   logic [7:0]            dataPeriod;
   logic [1:0]            dataTrim;
   logic                  fallEdge;
   logic                  riseEdge;
   logic                  riseBad;

   cwc_fs_tick #(
      .DIV (FS_DIV)
   ) u_fs_tick (
      .clk  (clk),
      .rst  (rst),
      .ce   (ce),
      .tick (fsTick)
   );

   assign wrTxEn = wrEn && (addr == `CWC_OFF_TXEN);

   // Receive limits from the configured trims
   assign limLateZero  = `CWC_L0_BASE + {5'h00, rxCfg.latestZero};
   assign limLateOne   = `CWC_L1_BASE + {5'h00, rxCfg.latestOne};
   assign limEarlyZero = `CWC_E0_BASE - {5'h00, rxCfg.earliestZero};
   assign limEarlyOne  = `CWC_E1_BASE - {5'h00, rxCfg.earliestOne};

   // Transmit timing from the configured trims
   assign startRise   = `CWC_SRISE_BASE - {5'h00, txCfg.startRise};
   assign startPeriod = `CWC_SPRD_BASE - {5'h00, txCfg.startPeriod};
   // Reserved data rise codes act as no trim
   assign dataTrim    = txCfg.dataRise[2] ? 2'h0
                        : txCfg.dataRise[1:0];
   assign dataRise    = (txShift[9] ? `CWC_DR1_BASE : `CWC_DR0_BASE)
                        - {6'h00, dataTrim};
   assign dataPeriod  = `CWC_DPRD_BASE - {4'h0, txCfg.dataPeriod};

   // Line edges from the previous sampled line level, own transmission included
   assign fallEdge = lineLast && !cecIn;
   assign riseEdge = !lineLast && cecIn;

   // Rise outside the legal one or zero windows
   assign riseBad = (rxCount < limEarlyOne)
                 || ((rxCount > limLateOne)
                     && (rxCount < limEarlyZero))
                 || (rxCount > limLateZero);

   always_comb begin
      waveErrEvt = 1'b0;
      if (fsTick || riseEdge) begin
         waveErrEvt = 1'b0;
      end
      if (rxEnable && rxCfg.waveEn && rxActive && !txTrans) begin
         if (riseEdge) begin
            waveErrEvt = riseBad;
         end else if (fsTick && !cecIn && (rxCount == limLateZero)) begin
            waveErrEvt = 1'b1;
         end
      end
   end

   // Line history for edge detection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lineLast <= 1'b1;
      end else if (ce) begin
         lineLast <= cecIn;
      end
   end

   // Bit timer restarts on every falling edge while receive is enabled and no transmission is in progress
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxActive <= 1'b0;
         rxCount  <= 8'h00;
      end else if (ce) begin
         if (!rxEnable || txTrans) begin
            rxActive <= 1'b0;
            rxCount  <= 8'h00;
         end else if (fallEdge) begin
            rxActive <= 1'b1;
            rxCount  <= 8'h00;
         end else if (riseEdge || waveErrEvt) begin
            rxActive <= 1'b0;
         end else if (rxActive && fsTick && rxCount != 8'hFF) begin
            rxCount  <= rxCount + 8'h01;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxEnable <= 1'b0;
         rxCfg    <= '0;
         txCfg    <= '0;
         txByte   <= 8'h00;
         txEom    <= 1'b0;
      end else if (ce && wrEn) begin
         case (addr)
            `CWC_OFF_RXEN: begin
               rxEnable <= wrData[0];
            end
            `CWC_OFF_RXCFG: begin
               rxCfg.waveEn       <= wrData[`CWC_RX_WAVEN];
               rxCfg.earliestOne  <= wrData[`CWC_RX_W0_LSB +: 3];
               rxCfg.latestOne    <= wrData[`CWC_RX_W1_LSB +: 3];
               rxCfg.earliestZero <= wrData[`CWC_RX_W2_LSB +: 3];
               rxCfg.latestZero   <= wrData[`CWC_RX_W3_LSB +: 3];
            end
            `CWC_OFF_TXBUF: begin
               txByte <= wrData[7:0];
               txEom  <= wrData[`CWC_TB_EOM];
            end
            `CWC_OFF_TXTCR: begin
               txCfg.startRise   <= wrData[`CWC_TC_STRS +: 3];
               txCfg.startPeriod <= wrData[`CWC_TC_SPRD +: 3];
               txCfg.dataRise    <= wrData[`CWC_TC_DTRS +: 3];
               txCfg.dataPeriod  <= wrData[`CWC_TC_DPRD +: 4];
               txCfg.broadcast   <= wrData[`CWC_TC_BRD];
               txCfg.busFree     <= wrData[`CWC_TC_FREE +: 4];
            end
            default: begin
            end
         endcase
      end
   end

   // Transmit enable and progress status
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txEnable <= 1'b0;
         txTrans  <= 1'b0;
      end else if (ce) begin
         if (txDoneEvt || waveErrEvt) begin
            txEnable <= 1'b0;
            txTrans  <= 1'b0;
         end else if (wrTxEn) begin
            txEnable <= wrData[`CWC_TX_EN];
            // Only bit 0 is taken, progress bit writes dropped
            txTrans  <= wrData[`CWC_TX_EN] && txEnable ? txTrans
                        : wrData[`CWC_TX_EN];
         end
      end
   end

   // Transmit sequencer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txState   <= cwc_pkg::CWC_TX_IDLE;
         txCount   <= 8'h00;
         txBitIdx  <= 4'h0;
         txShift   <= 10'h000;
         txDoneEvt <= 1'b0;
      end else if (ce) begin
         txDoneEvt <= 1'b0;
         if (!txEnable || !txTrans) begin
            txState <= cwc_pkg::CWC_TX_IDLE;
            if (wrTxEn && wrData[`CWC_TX_EN] && !txEnable) begin
               txState  <= cwc_pkg::CWC_TX_SLOW;
               txCount  <= 8'h00;
               txBitIdx <= 4'h0;
               txShift  <= {txByte, txEom, 1'b1};
            end
         end else if (fsTick) begin
            txCount <= txCount + 8'h01;
            case (txState)
               cwc_pkg::CWC_TX_SLOW: begin
                  if (txCount + 8'h01 == startRise) begin
                     txState <= cwc_pkg::CWC_TX_SHIGH;
                  end
               end
               cwc_pkg::CWC_TX_SHIGH: begin
                  if (txCount + 8'h01 == startPeriod) begin
                     txState <= cwc_pkg::CWC_TX_DLOW;
                     txCount <= 8'h00;
                  end
               end
               cwc_pkg::CWC_TX_DLOW: begin
                  if (txCount + 8'h01 == dataRise) begin
                     txState <= cwc_pkg::CWC_TX_DHIGH;
                  end
               end
               cwc_pkg::CWC_TX_DHIGH: begin
                  if (txCount + 8'h01 == dataPeriod) begin
                     txCount  <= 8'h00;
                     txShift  <= {txShift[8:0], 1'b0};
                     txBitIdx <= txBitIdx + 4'h1;
                     if (txBitIdx == `CWC_NBITS - 4'h1) begin
                        txState   <= cwc_pkg::CWC_TX_IDLE;
                        txDoneEvt <= 1'b1;
                     end else begin
                        txState <= cwc_pkg::CWC_TX_DLOW;
                     end
                  end
               end
               default: begin
                  txState <= cwc_pkg::CWC_TX_IDLE;
               end
            endcase
         end
      end
   end

   // Open-drain line drive, enable low pulls the line
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cecOut <= 1'b0;
         cecOeN <= 1'b1;
      end else if (ce) begin
         cecOut <= 1'b0;
         cecOeN <= !(txEnable && txTrans
                  && (txState == cwc_pkg::CWC_TX_SLOW
                   || txState == cwc_pkg::CWC_TX_DLOW));
      end
   end

   // Sticky status, set wins over write-one clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waveErrFlag <= 1'b0;
         txDoneFlag  <= 1'b0;
         waveErrReq  <= 1'b0;
         txDoneReq   <= 1'b0;
      end else if (ce) begin
         waveErrReq <= waveErrEvt;
         txDoneReq  <= txDoneEvt;
         if (waveErrEvt) begin
            waveErrFlag <= 1'b1;
         end else if (wrEn && addr == `CWC_OFF_STAT
                      && wrData[`CWC_ST_WERR]) begin
            waveErrFlag <= 1'b0;
         end
         if (txDoneEvt) begin
            txDoneFlag <= 1'b1;
         end else if (wrEn && addr == `CWC_OFF_STAT
                      && wrData[`CWC_ST_TDONE]) begin
            txDoneFlag <= 1'b0;
         end
      end
   end

   // Read data one cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdData <= `CWC_RST_REG;
      end else if (ce) begin
         rdData <= `CWC_RST_REG;
         if (rdEn) begin
            case (addr)
               `CWC_OFF_RXEN: begin
                  rdData[0] <= rxEnable;
               end
               `CWC_OFF_RXCFG: begin
                  rdData[`CWC_RX_WAVEN]      <= rxCfg.waveEn;
                  rdData[`CWC_RX_W0_LSB +: 3] <= rxCfg.earliestOne;
                  rdData[`CWC_RX_W1_LSB +: 3] <= rxCfg.latestOne;
                  rdData[`CWC_RX_W2_LSB +: 3] <= rxCfg.earliestZero;
                  rdData[`CWC_RX_W3_LSB +: 3] <= rxCfg.latestZero;
               end
               `CWC_OFF_TXEN: begin
                  // Enable is write-only, only progress is visible
                  rdData[`CWC_TX_TRANS] <= txTrans;
               end
               `CWC_OFF_TXBUF: begin
                  rdData[7:0]          <= txByte;
                  rdData[`CWC_TB_EOM]  <= txEom;
               end
               `CWC_OFF_TXTCR: begin
                  rdData[`CWC_TC_STRS +: 3] <= txCfg.startRise;
                  rdData[`CWC_TC_SPRD +: 3] <= txCfg.startPeriod;
                  rdData[`CWC_TC_DTRS +: 3] <= txCfg.dataRise;
                  rdData[`CWC_TC_DPRD +: 4] <= txCfg.dataPeriod;
                  rdData[`CWC_TC_BRD]       <= txCfg.broadcast;
                  rdData[`CWC_TC_FREE +: 4] <= txCfg.busFree;
               end
               `CWC_OFF_STAT: begin
                  rdData[`CWC_ST_WERR]  <= waveErrFlag;
                  rdData[`CWC_ST_TDONE] <= txDoneFlag;
               end
               default: begin
                  rdData <= `CWC_RST_REG;
               end
            endcase
         end
      end
   end

endmodule // cwc_top

// ===== cwc_params.svh
`ifndef CWC_PARAMS_SVH
`define CWC_PARAMS_SVH
// Contract
// - Flag error when a rise comes after 56 fs plus latest-zero setting.
// - Flag error when no rise is seen before the latest-zero limit.
// - Flag error for a rise between latest-one and earliest-zero limits.
// - Flag error when a rise comes before 13 fs minus earliest-one setting.
// - All four rise checks act only while waveform check enable is 1.
// - Transmit-in-progress sets at start bit, clears on completion or error.
// - Writes to the transmit-in-progress bit are ignored.
// - Writing 1 to transmit enable bit 0 starts; writing 0 disables.
// - Transmit enable self-clears on completion or error event.
// - Transmit buffer bits 7 to 0 hold the byte, bit 7 sent first.
// - Transmit buffer bit 8 holds the end-of-message bit to send.
// - Start bit rises at 121 fs minus start rise trim.
// - Start bit lasts 147 fs minus start period trim.
// - Data bit rises at 20 or 49 fs minus trim 0..3; 4..7 reserved.
// - Data bit lasts 79 fs minus data period trim.

// Register byte offsets
`define CWC_OFF_RXEN   8'h00
`define CWC_OFF_RXCFG  8'h04
`define CWC_OFF_TXEN   8'h08
`define CWC_OFF_TXBUF  8'h0C
`define CWC_OFF_TXTCR  8'h10
`define CWC_OFF_STAT   8'h14

// Field positions
`define CWC_RX_WAVEN   0
`define CWC_RX_W0_LSB  8
`define CWC_RX_W1_LSB  12
`define CWC_RX_W2_LSB  16
`define CWC_RX_W3_LSB  20
`define CWC_TX_EN      0
`define CWC_TX_TRANS   1
`define CWC_TB_EOM     8
`define CWC_TC_STRS    20
`define CWC_TC_SPRD    16
`define CWC_TC_DTRS    12
`define CWC_TC_DPRD    8
`define CWC_TC_BRD     4
`define CWC_TC_FREE    0
`define CWC_ST_WERR    0
`define CWC_ST_TDONE   1

// Reset values
`define CWC_RST_REG    32'h0000_0000

// Timing in fs periods, then data bits per frame
`define CWC_E1_BASE    8'h0D
`define CWC_L1_BASE    8'h1A
`define CWC_E0_BASE    8'h2B
`define CWC_L0_BASE    8'h38
`define CWC_SRISE_BASE 8'h79
`define CWC_SPRD_BASE  8'h93
`define CWC_DR1_BASE   8'h14
`define CWC_DR0_BASE   8'h31
`define CWC_DPRD_BASE  8'h4F
`define CWC_NBITS      4'hA

// fs time base
`define CWC_CLK_NS     50
`define CWC_FS_NS      30518
`define CWC_FS_DIV     (`CWC_FS_NS / `CWC_CLK_NS)
`endif

// ===== cwc_pkg.sv
package cwc_pkg;
   typedef struct packed {
      logic [2:0] latestZero;
      logic [2:0] earliestZero;
      logic [2:0] latestOne;
      logic [2:0] earliestOne;
      logic       waveEn;
   } cwc_rx_cfg_t;

   typedef struct packed {
      logic [2:0] startRise;
      logic [2:0] startPeriod;
      logic [2:0] dataRise;
      logic [3:0] dataPeriod;
      logic       broadcast;
      logic [3:0] busFree;
   } cwc_tx_cfg_t;

   typedef enum logic [2:0] {
      CWC_TX_IDLE  = 3'h0,
      CWC_TX_SLOW  = 3'h1,
      CWC_TX_SHIGH = 3'h2,
      CWC_TX_DLOW  = 3'h3,
      CWC_TX_DHIGH = 3'h4
   } cwc_tx_state_t;
endpackage

// ===== cwc_fs_tick.sv
`timescale 1ns/100ps
module cwc_fs_tick #(
   parameter int DIV = 610
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   output logic      tick
);
   logic [15:0] count;

   // Divides clk down to one pulse per fs period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end else if (ce) begin
         if (count == 16'(DIV - 1)) begin
            count <= 16'h0000;
            tick  <= 1'b1;
         end else begin
            count <= count + 16'h0001;
            tick  <= 1'b0;
         end
      end
   end
endmodule // cwc_fs_tick

// ===== cwc_top_assertions.sv
`timescale 1ns/100ps
module cwc_top_checker #(
   parameter int FS_DIV = 4
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wrData,
   input wire logic        wrEn,
   input wire logic        rdEn,
   input wire logic [31:0] rdData,
   input wire logic        cecIn,
   input wire logic        cecOut,
   input wire logic        cecOeN,
   input wire logic        waveErrReq,
   input wire logic        txDoneReq
);
   localparam int LOW_MAX = 121 * FS_DIV + 2;
   logic [15:0] lowCnt;

   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   // Length of the current low drive
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lowCnt <= 16'h0000;
      end else if (!cecOeN) begin
         lowCnt <= lowCnt + 16'h0001;
      end else begin
         lowCnt <= 16'h0000;
      end
   end

   rd_idle_a: assert property (!$past(rdEn) |-> rdData == 32'h0)
      else $error("read data not zero outside answer cycle");
   buf_upper_a: assert property (rdEn && addr == 8'h0C |=>
      rdData[31:9] == 23'h0) else $error("buffer upper bits not zero");
   en_wo_a: assert property (rdEn && addr == 8'h08 |=>
      rdData[0] == 1'b0 && rdData[31:2] == 30'h0)
      else $error("enable register read wrong");
   buf_echo_a: assert property (wrEn && addr == 8'h0C ##2
      rdEn && addr == 8'h0C |=> rdData == ($past(wrData, 3) & 32'h1FF))
      else $error("buffer read back differs");
   start_flag_a: assert property (wrEn && addr == 8'h08 && wrData[0]
      ##2 rdEn && addr == 8'h08 |=> rdData[1])
      else $error("in progress flag not set");
   err_pulse_a: assert property (waveErrReq |=> !waveErrReq)
      else $error("wave error request too long");
   done_pulse_a: assert property (txDoneReq |-> cecOeN ##1 !txDoneReq)
      else $error("done request wrong");
   stop_release_a: assert property (wrEn && addr == 8'h08
      && !wrData[0] |-> ##2 cecOeN) else $error("line not released");
   out_zero_a: assert property (cecOut == 1'b0)
      else $error("line output not low");
   low_bound_a: assert property (lowCnt <= 16'(LOW_MAX))
      else $error("line held low too long");
endmodule // cwc_top_checker

bind cwc_top cwc_top_checker #(.FS_DIV(FS_DIV)) checker_i (
   .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wrData(wrData),
   .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .cecIn(cecIn),
   .cecOut(cecOut), .cecOeN(cecOeN), .waveErrReq(waveErrReq),
   .txDoneReq(txDoneReq)
);

// ===== cwc_line_node.sv
`timescale 1ns/100ps
module cwc_line_node (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        go,
   input  wire logic [15:0] lowCycles,
   output logic             nodeOeN
);
   logic [15:0] left;

   // Pulls the line low for a set span; pull-up restores it after
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         left <= 16'h0000;
      end else if (go) begin
         left <= lowCycles;
      end else if (left != 16'h0000) begin
         left <= left - 16'h0001;
      end
   end

   assign nodeOeN = (left == 16'h0000);
endmodule // cwc_line_node

// ===== cwc_top_tb.sv
`timescale 1ns/100ps
`define CHK(g, e, m) chk(32'(g), 32'(e), m)
module cwc_top_tb;
   localparam int FS = 4;
   typedef struct {
      logic [31:0] cfg;
      int          ticks;
      logic        err;
   } cwc_row_t;

   logic        clk, rst, ce, wrEn, rdEn, nodeGo, nodeOeN, cecLine;
   logic        cecOut, cecOeN, waveErrReq, txDoneReq;
   logic [7:0]  addr;
   logic [31:0] wrData, rdData, d;
   logic [15:0] nodeLow;
   logic [9:0]  bits = 10'b1010_0101_11;
   int          miscompares, checkCount, errSeen, doneSeen;
   int          lo, hi, loE, prE;
   cwc_row_t    rows [11] = '{
      '{32'h0000_0001, 6, 1'b1}, '{32'h0000_0001, 20, 1'b0},
      '{32'h0000_0001, 34, 1'b1}, '{32'h0000_0001, 50, 1'b0},
      '{32'h0000_0001, 70, 1'b1}, '{32'h0000_0000, 6, 1'b0},
      '{32'h0000_0000, 70, 1'b0}, '{32'h0000_0701, 9, 1'b0},
      '{32'h0070_0001, 60, 1'b0}, '{32'h0000_7001, 30, 1'b0},
      '{32'h0007_0001, 38, 1'b0}};
   logic [71:0] regRows [6] = '{
      {8'h18, 32'hFFFF_FFFF, 32'h0000_0000},
      {8'h08, 32'h0000_0002, 32'h0000_0000},
      {8'h0C, 32'hFFFF_FFFF, 32'h0000_01FF},
      {8'h0C, 32'h0000_01A5, 32'h0000_01A5},
      {8'h10, 32'hFFFF_FFFF, 32'h0077_7F1F},
      {8'h04, 32'hFFFF_FFFF, 32'h0077_7701}};

   cwc_top #(.FS_DIV(FS)) dut (
      .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wrData(wrData),
      .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .cecIn(cecLine),
      .cecOut(cecOut), .cecOeN(cecOeN), .waveErrReq(waveErrReq),
      .txDoneReq(txDoneReq));
   cwc_line_node node (
      .clk(clk), .rst(rst), .go(nodeGo), .lowCycles(nodeLow),
      .nodeOeN(nodeOeN));

   // Open-drain line with pull-up
   assign cecLine = (cecOeN | cecOut) & nodeOeN;

   always #25 clk = ~clk;

   always @(posedge clk) begin
      if (waveErrReq === 1'b1) errSeen++;
      if (txDoneReq === 1'b1) doneSeen++;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      checkCount++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t %s: got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic bus(input logic w, input logic r, input logic [7:0] a,
                      input logic [31:0] v);
      wrEn <= w;
      rdEn <= r;
      addr <= a;
      wrData <= v;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bus(1'b1, 1'b0, a, v);
      bus(1'b0, 1'b0, a, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      bus(1'b0, 1'b1, a, 32'h0);
      bus(1'b0, 1'b0, a, 32'h0);
      v = rdData;
   endtask

   task automatic count_level(input logic lv, output int n);
      n = 0;
      while (cecLine === lv && n < 2000) begin
         @(posedge clk);
         n++;
      end
   endtask

   function automatic bit near(input int v, input int e);
      return (v > e - 5) && (v < e + 5);
   endfunction

   task automatic test_done();
      $display("checks %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #(60_000 * 50);
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      test_done();
   end

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      wrEn = 1'b0;
      rdEn = 1'b0;
      addr = 8'h00;
      wrData = 32'h0;
      nodeGo = 1'b0;
      nodeLow = 16'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a < 7; a++) begin
         rd(8'(a * 4), d);
         `CHK(d, 32'h0, "reset value");
      end
      for (int i = 0; i < 6; i++) begin
         wr(regRows[i][71:64], regRows[i][63:32]);
         rd(regRows[i][71:64], d);
         `CHK(d, regRows[i][31:0], "reg access");
      end
      $display("register test done");
      ce <= 1'b0;
      wr(8'h0C, 32'h0000_00FF);
      ce <= 1'b1;
      @(posedge clk);
      rd(8'h0C, d);
      `CHK(d, 32'h0000_01A5, "frozen write");
      $display("clock enable test done");
      for (int i = 0; i < 11; i++) begin
         wr(8'h00, 32'h0);
         rd(8'h00, d);
         `CHK(d, 32'h0, "rx stopped");
         wr(8'h04, rows[i].cfg);
         wr(8'h14, 32'h3);
         wr(8'h00, 32'h1);
         errSeen = 0;
         nodeLow <= 16'(rows[i].ticks * FS);
         nodeGo <= 1'b1;
         @(posedge clk);
         nodeGo <= 1'b0;
         repeat (rows[i].ticks * FS + 20) @(posedge clk);
         `CHK(errSeen != 0, rows[i].err, "wave error");
         rd(8'h14, d);
         `CHK(d[0], rows[i].err, "wave status");
         $display("rx row %0d done", i);
      end
      wr(8'h00, 32'h0);
      wr(8'h10, 32'h0032_2500);
      wr(8'h0C, 32'h0000_01A5);
      wr(8'h08, 32'h1);
      count_level(1'b1, lo);
      for (int i = 0; i < 11; i++) begin
         count_level(1'b0, lo);
         count_level(1'b1, hi);
         loE = (i == 0) ? 118 * FS : (bits[10 - i] ? 18 * FS : 47 * FS);
         prE = (i == 0) ? 145 * FS : 74 * FS;
         `CHK(near(lo, loE), 1'b1, "low span");
         if (i < 10) `CHK(near(lo + hi, prE), 1'b1, "bit period");
      end
      `CHK(doneSeen, 1, "tx done");
      rd(8'h08, d);
      `CHK(d, 32'h0, "tx idle");
      rd(8'h14, d);
      `CHK(d, 32'h2, "done status");
      $display("transmit test done");
      wr(8'h10, 32'h0000_7000);
      wr(8'h08, 32'h1);
      rd(8'h08, d);
      `CHK(d, 32'h2, "in progress");
      count_level(1'b1, lo);
      count_level(1'b0, lo);
      count_level(1'b1, hi);
      count_level(1'b0, lo);
      `CHK(near(lo, 20 * FS), 1'b1, "reserved trim");
      wr(8'h08, 32'h0);
      repeat (2) @(posedge clk);
      `CHK(cecLine, 1'b1, "line released");
      rd(8'h08, d);
      `CHK(d, 32'h0, "tx stopped");
      $display("abort test done");
      test_done();
   end
endmodule // cwc_top_tb
